// ---- design/psv_regs.svh ----
/*
 * Link codes, controller register map and timing.
 * Assumes inclusion by bare name.
 */
`ifndef PSV_REGS_SVH
`define PSV_REGS_SVH

// ==========
// Target addressing and data codes
`define PSV_TGT_ADDR 7'h40
`define PSV_SEL_CHAN 8'h00
`define PSV_SEL_FREQ 8'h01
`define PSV_FREQ_INIT 3'h0
`define PSV_FREQ_P10 3'h1
`define PSV_FREQ_P20 3'h2
`define PSV_FREQ_M20 3'h3
`define PSV_FREQ_M10 3'h4

// ==========
// Controller registers
`define PSV_REG_CMD 8'h00
`define PSV_REG_SEL 8'h04
`define PSV_REG_WDATA 8'h08
`define PSV_REG_RDATA 8'h0C
`define PSV_REG_STS 8'h10
`define PSV_REG_MASK 8'h14
`define PSV_CMD_GO 0
`define PSV_CMD_READ 1
`define PSV_STS_DONE 0
`define PSV_STS_NACK 1
`define PSV_STS_BUSY 2
`define PSV_MASK_RST 2'h0
`define PSV_CTL_RST 8'h00

// ==========
// Timing
`define PSV_CLK_NS 5
`define PSV_FSCL_KHZ 100
`define PSV_QTR_NS (1000000 / (4 * `PSV_FSCL_KHZ))
`define PSV_QTR_CYC ((`PSV_QTR_NS + `PSV_CLK_NS - 1) / `PSV_CLK_NS)

`endif

// ---- design/psv_pkg.sv ----
/*
 * State types of both ends.
 * Assumes nothing.
 */
package psv_pkg;

    // ======================================================
    // State types
    typedef enum logic [2:0] {
        PSV_T_IDLE, PSV_T_RX, PSV_T_ACK, PSV_T_TX, PSV_T_TXACK, PSV_T_SKIP
    } psv_tstate_t;

    typedef enum logic [2:0] {
        PSV_H_IDLE, PSV_H_START, PSV_H_BIT, PSV_H_STOP, PSV_H_FREE
    } psv_hstate_t;

endpackage : psv_pkg

// ---- design/psv_bus_if.sv ----
/*
 * Open-drain bus joining both ends.
 * Assumes each end drives only its enables.
 */
`timescale 1ns/1ps
interface psv_bus_if;

    // ======================================================
    // Drives
    logic hostSclO;
    logic hostSclOe;
    logic hostSdaO;
    logic hostSdaOe;
    logic devSdaO;
    logic devSdaOe;

    // ======================================================
    // Wired lines, pulled up
    logic scl;
    logic sda;
    assign scl = ~(hostSclOe & ~hostSclO);
    assign sda = ~(hostSdaOe & ~hostSdaO) & ~(devSdaOe & ~devSdaO);

    modport host (output hostSclO, hostSclOe, hostSdaO, hostSdaOe, input sda);
    modport target (output devSdaO, devSdaOe, input scl, sda);

endinterface : psv_bus_if

// ---- design/psv_sync.sv ----
/*
 * Two-flop synchroniser.
 * Assumes independent levels.
 */
`timescale 1ns/1ps
module psv_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : psv_sync

// ---- design/psv_target.sv ----
/*
 * Target end: channel enables, frequency code, status byte.
 * Assumes bus lines and detector levels are asynchronous.
 */
`timescale 1ns/1ps
`include "psv_regs.svh"
module psv_target
    import psv_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Two-wire bus
    psv_bus_if.target bus,
    // Detector levels
    input wire logic uvFlag,
    input wire logic ovFlag,
    input wire logic [2:0] shortCircuitFlag,
    // Channel controls
    output logic [2:0] high_side_switch_enable,
    output logic [2:0] converter_enable,
    output logic [2:0] freqAdjust
);

    // ==========
    // Input synchronisers
    logic [6:0] syn;
    logic sclS;
    logic sdaS;
    logic [7:0] statusByte;

    psv_sync #(.W(7)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({bus.scl, bus.sda, shortCircuitFlag, ovFlag, uvFlag}),
        .q(syn)
    );

    assign sclS = syn[6];
    assign sdaS = syn[5];
    assign statusByte = {3'h0, syn[2], syn[3], syn[4], syn[1], syn[0]};

    // ==========
    // Edge and condition detection
    logic sclP_q;
    logic sdaP_q;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
        end else begin
            sclP_q <= sclS;
            sdaP_q <= sdaS;
        end
    end

    assign sclRise = sclS & ~sclP_q;
    assign sclFall = ~sclS & sclP_q;
    assign startSeen = sclS & sclP_q & sdaP_q & ~sdaS;
    assign stopSeen = sclS & sclP_q & ~sdaP_q & sdaS;

    // ==========
    // Byte acceptance
    psv_tstate_t state_q;
    logic [3:0] bitCnt_q;
    logic [1:0] byteNo_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] sel_q;
    logic rnw_q;
    logic sdaOe_q;
    logic byteDone;
    logic accept;

    assign byteDone = (state_q == PSV_T_RX) && sclFall && (bitCnt_q == 4'h8);

    always_comb begin
        unique case (byteNo_q)
            2'h0: accept = (shift_q[7:1] == `PSV_TGT_ADDR);
            2'h1: accept = ~rnw_q && ((shift_q == `PSV_SEL_CHAN)
                || (shift_q == `PSV_SEL_FREQ));
            2'h2: accept = ~rnw_q;
            default: accept = 1'b0;
        endcase
    end

    // ==========
    // Protocol state machine
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PSV_T_IDLE;
            bitCnt_q <= 4'h0;
            byteNo_q <= 2'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            rnw_q <= 1'b0;
            sdaOe_q <= 1'b0;
        end else if (stopSeen) begin
            state_q <= PSV_T_IDLE;
            sdaOe_q <= 1'b0;
        end else if (startSeen) begin
            state_q <= PSV_T_RX;
            bitCnt_q <= 4'h0;
            byteNo_q <= 2'h0;
            sdaOe_q <= 1'b0;
        end else begin
            unique case (state_q)
                PSV_T_IDLE, PSV_T_SKIP: begin
                    sdaOe_q <= 1'b0;
                end
                PSV_T_RX: begin
                    if (sclRise) begin
                        shift_q <= {shift_q[6:0], sdaS};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (byteDone) begin
                        bitCnt_q <= 4'h0;
                        if (byteNo_q == 2'h0) begin
                            rnw_q <= shift_q[0];
                        end
                        if (accept) begin
                            state_q <= PSV_T_ACK;
                            sdaOe_q <= 1'b1;
                        end else begin
                            state_q <= PSV_T_SKIP;
                        end
                    end
                end
                PSV_T_ACK: begin
                    if (sclFall) begin
                        byteNo_q <= byteNo_q + 2'h1;
                        if (rnw_q && byteNo_q == 2'h0) begin
                            state_q <= PSV_T_TX;
                            tx_q <= statusByte;
                            sdaOe_q <= ~statusByte[7];
                        end else begin
                            state_q <= PSV_T_RX;
                            sdaOe_q <= 1'b0;
                        end
                    end
                end
                PSV_T_TX: begin
                    if (sclFall) begin
                        if (bitCnt_q == 4'h7) begin
                            state_q <= PSV_T_TXACK;
                            sdaOe_q <= 1'b0;
                        end else begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                            tx_q <= {tx_q[6:0], 1'b0};
                            sdaOe_q <= ~tx_q[6];
                        end
                    end
                end
                PSV_T_TXACK: begin
                    if (sclRise) begin
                        state_q <= PSV_T_SKIP;
                    end
                end
            endcase
        end
    end

    // ==========
    // Select byte capture
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= `PSV_SEL_CHAN;
        end else if (byteDone && accept && byteNo_q == 2'h1) begin
            sel_q <= shift_q;
        end
    end

    // ==========
    // Channel enables
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            high_side_switch_enable <= 3'h0;
            converter_enable <= 3'h0;
        end else if (byteDone && accept && byteNo_q == 2'h2
            && sel_q == `PSV_SEL_CHAN) begin
            converter_enable <= {shift_q[4], shift_q[2], shift_q[0]};
            high_side_switch_enable <= {shift_q[5], shift_q[3], shift_q[1]};
        end
    end

    // ==========
    // Frequency tuning
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            freqAdjust <= `PSV_FREQ_INIT;
        end else if (byteDone && accept && byteNo_q == 2'h2
            && sel_q == `PSV_SEL_FREQ && shift_q[7:3] == 5'h00
            && shift_q[2:0] <= `PSV_FREQ_M10) begin
            freqAdjust <= shift_q[2:0];
        end
    end

    // ==========
    // Open-drain drive
    assign bus.devSdaO = 1'b0;
    assign bus.devSdaOe = sdaOe_q;

endmodule : psv_target

// ---- design/psv_host.sv ----
/*
 * Controller end: APB registers drive one link transfer; irq.
 * Assumes an APB master on clk_sys.
 */
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "psv_regs.svh"
module psv_host
    import psv_pkg::*;
#(
    parameter int QTR_CYC = `PSV_QTR_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Two-wire bus
    psv_bus_if.host bus
);

    // ==========
    // APB slave
    psv_hstate_t state_q;
    logic [7:0] sel_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic [1:0] sts_q;
    logic [1:0] mask_q;
    logic rnw_q;
    logic doneEv;
    logic nackEv;
    logic access;
    logic wr;
    logic go;
    logic mapped;

    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign go = wr && paddr == `PSV_REG_CMD && pwdata[`PSV_CMD_GO]
        && state_q == PSV_H_IDLE;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= `PSV_REG_MASK;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata <= 32'h0000_0000;
            if (psel & penable & ~pready & ~pwrite) begin
                unique case (paddr)
                    `PSV_REG_SEL: prdata <= {24'h0, sel_q};
                    `PSV_REG_WDATA: prdata <= {24'h0, wdata_q};
                    `PSV_REG_RDATA: prdata <= {24'h0, rdata_q};
                    `PSV_REG_STS: prdata <= {29'h0, state_q != PSV_H_IDLE, sts_q};
                    `PSV_REG_MASK: prdata <= {30'h0, mask_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= `PSV_CTL_RST;
            wdata_q <= `PSV_CTL_RST;
            mask_q <= `PSV_MASK_RST;
            rnw_q <= 1'b0;
        end else if (wr) begin
            if (paddr == `PSV_REG_SEL) sel_q <= pwdata[7:0];
            if (paddr == `PSV_REG_WDATA) wdata_q <= pwdata[7:0];
            if (paddr == `PSV_REG_MASK) mask_q <= pwdata[1:0];
            if (go) rnw_q <= pwdata[`PSV_CMD_READ];
        end
    end

    // ==========
    // Sticky status and interrupt, set wins over read clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sts_q <= 2'h0;
            irq <= 1'b0;
        end else begin
            sts_q <= ((access && !pwrite && paddr == `PSV_REG_STS) ? 2'h0 : sts_q)
                | {nackEv, doneEv};
            irq <= |(sts_q & mask_q);
        end
    end

    // ==========
    // Quarter-period timing
    logic [15:0] qCnt_q;
    logic [1:0] ph_q;
    logic tick;
    logic sdaS;

    assign tick = (state_q != PSV_H_IDLE) && (qCnt_q == 16'(QTR_CYC - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qCnt_q <= 16'h0000;
            ph_q <= 2'h0;
        end else if (state_q == PSV_H_IDLE || tick) begin
            qCnt_q <= 16'h0000;
            ph_q <= (state_q == PSV_H_IDLE) ? 2'h0 : ph_q + 2'h1;
        end else begin
            qCnt_q <= qCnt_q + 16'h0001;
        end
    end

    psv_sync #(.W(1)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(bus.sda),
        .q(sdaS)
    );

    // ==========
    // Transfer sequencer
    logic [3:0] bitCnt_q;
    logic [1:0] byteNo_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic sclOe_q;
    logic sdaOe_q;
    logic isRx;
    logic lastByte;

    assign isRx = rnw_q && byteNo_q == 2'h1;
    assign lastByte = rnw_q ? byteNo_q == 2'h1 : byteNo_q == 2'h2;
    assign doneEv = tick && state_q == PSV_H_FREE && ph_q == 2'h3;
    assign nackEv = tick && state_q == PSV_H_BIT && ph_q == 2'h3
        && bitCnt_q == 4'h8 && !isRx && sdaS;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PSV_H_IDLE;
            bitCnt_q <= 4'h0;
            byteNo_q <= 2'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            rdata_q <= 8'h00;
            sclOe_q <= 1'b0;
            sdaOe_q <= 1'b0;
        end else if (go) begin
            state_q <= PSV_H_START;
            bitCnt_q <= 4'h0;
            byteNo_q <= 2'h0;
            tx_q <= {`PSV_TGT_ADDR, pwdata[`PSV_CMD_READ]};
        end else if (tick) begin
            unique case (state_q)
                PSV_H_IDLE: begin
                end
                PSV_H_START: begin
                    if (ph_q == 2'h0) sdaOe_q <= 1'b1;
                    if (ph_q == 2'h3) state_q <= PSV_H_BIT;
                end
                PSV_H_BIT: begin
                    if (ph_q == 2'h0) begin
                        sclOe_q <= 1'b1;
                        sdaOe_q <= bitCnt_q != 4'h8 && !isRx && !tx_q[7];
                    end
                    if (ph_q == 2'h2) sclOe_q <= 1'b0;
                    if (ph_q == 2'h3) begin
                        if (bitCnt_q != 4'h8) begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                            tx_q <= {tx_q[6:0], 1'b0};
                            rx_q <= {rx_q[6:0], sdaS};
                        end else begin
                            bitCnt_q <= 4'h0;
                            byteNo_q <= byteNo_q + 2'h1;
                            tx_q <= (byteNo_q == 2'h0) ? sel_q : wdata_q;
                            if (nackEv || lastByte) state_q <= PSV_H_STOP;
                            if (isRx) rdata_q <= rx_q;
                        end
                    end
                end
                PSV_H_STOP: begin
                    if (ph_q == 2'h0) begin
                        sclOe_q <= 1'b1;
                        sdaOe_q <= 1'b1;
                    end
                    if (ph_q == 2'h2) sclOe_q <= 1'b0;
                    if (ph_q == 2'h3) state_q <= PSV_H_FREE;
                end
                PSV_H_FREE: begin
                    if (ph_q == 2'h1) sdaOe_q <= 1'b0;
                    if (ph_q == 2'h3) state_q <= PSV_H_IDLE;
                end
            endcase
        end
    end

    assign bus.hostSclO = 1'b0;
    assign bus.hostSdaO = 1'b0;
    assign bus.hostSclOe = sclOe_q;
    assign bus.hostSdaOe = sdaOe_q;

endmodule : psv_host

// ---- dv/psv_checker.sv ----
/* Assertions on the two-wire bus.
   Assumes inputs from the bus interface. */
`timescale 1ns/1ps
`include "psv_regs.svh"
module psv_checker #(
    parameter int QTR_CYC = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Drives
    input wire logic hostSclO,
    input wire logic hostSclOe,
    input wire logic hostSdaO,
    input wire logic hostSdaOe,
    input wire logic devSdaO,
    input wire logic devSdaOe,
    // Lines
    input wire logic scl,
    input wire logic sda
);
    localparam int HI_MIN = 8 * QTR_CYC / 5;
    localparam int LO_MIN = 47 * QTR_CYC / 25;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ======================================================
    // Line events and phase counters
    logic sclP_q, sdaP_q, rw_q, rise, fall, start, stop;
    logic [19:0] loCnt_q, hiCnt_q, freeCnt_q, stCnt_q;
    logic [3:0] bitCnt_q;
    logic [1:0] byteIdx_q;
    logic [7:0] sh_q;
    assign rise = scl & ~sclP_q;
    assign fall = ~scl & sclP_q;
    assign start = scl & sclP_q & sdaP_q & ~sda;
    assign stop = scl & sclP_q & ~sdaP_q & sda;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclP_q <= 1'h1;
            sdaP_q <= 1'h1;
            loCnt_q <= 20'h0;
            hiCnt_q <= 20'(HI_MIN);
            freeCnt_q <= 20'(LO_MIN);
            stCnt_q <= 20'(HI_MIN);
        end else begin
            sclP_q <= scl;
            sdaP_q <= sda;
            loCnt_q <= scl ? 20'h0 : loCnt_q + 20'h1;
            hiCnt_q <= scl ? hiCnt_q + 20'h1 : 20'h0;
            freeCnt_q <= sda ? freeCnt_q + 20'h1 : 20'h0;
            stCnt_q <= start ? 20'h0 : stCnt_q + 20'h1;
        end
    end

    // ======================================================
    // Bit and byte tracking
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_q <= 4'h0;
            byteIdx_q <= 2'h0;
            sh_q <= 8'h0;
            rw_q <= 1'h0;
        end else if (start) begin
            bitCnt_q <= 4'h0;
            byteIdx_q <= 2'h0;
        end else if (rise) begin
            if (bitCnt_q == 4'h8) begin
                bitCnt_q <= 4'h0;
                byteIdx_q <= (byteIdx_q == 2'h3) ? 2'h3 : byteIdx_q + 2'h1;
            end else begin
                bitCnt_q <= bitCnt_q + 4'h1;
                sh_q <= {sh_q[6:0], sda};
            end
            if (bitCnt_q == 4'h7 && byteIdx_q == 2'h0) begin
                rw_q <= sda;
            end
        end
    end

    // ======================================================
    // Assertions
    a_open_drain: assert property (!hostSclO && !hostSdaO && !devSdaO)
        else $error("bus line driven high");
    a_scl_low: assert property (rise |-> loCnt_q >= LO_MIN)
        else $error("scl low phase short");
    a_scl_high: assert property (fall |-> hiCnt_q >= HI_MIN)
        else $error("scl high phase short");
    a_bus_free: assert property (start |-> freeCnt_q >= LO_MIN)
        else $error("bus free time short");
    a_start_hold: assert property (fall |-> stCnt_q >= HI_MIN)
        else $error("start hold short");
    a_stop_setup: assert property (stop |-> hiCnt_q >= HI_MIN)
        else $error("stop setup short");
    a_dev_steady: assert property (scl && sclP_q |-> $stable(devSdaOe))
        else $error("target sda moved while scl high");
    a_addr_ack: assert property (rise && bitCnt_q == 4'h8 && byteIdx_q == 2'h0
        && sh_q[7:1] == `PSV_TGT_ADDR |-> devSdaOe && !sda)
        else $error("own address not acknowledged");
    a_rd_release: assert property (rise && byteIdx_q == 2'h1 && rw_q
        && bitCnt_q != 4'h8 |-> !hostSdaOe)
        else $error("controller drives during status byte");
    a_rd_upper: assert property (rise && byteIdx_q == 2'h1 && rw_q
        && bitCnt_q < 4'h3 |-> !sda)
        else $error("status upper bits not zero");
    c_start: cover property (start);
    c_write: cover property (stop && !rw_q);
    c_read: cover property (rise && byteIdx_q == 2'h1 && rw_q && bitCnt_q == 4'h8);
endmodule : psv_checker

// ---- dv/power_supervisor_i2c_target_tb.sv ----
/* Bench of both ends plus a hand-driven second target.
   Assumes design files compiled first. */
`timescale 1ns/1ps
`include "psv_regs.svh"
module power_supervisor_i2c_target_tb
    import psv_pkg::*;
;
    localparam int QTR = 20;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq, uvFlag, ovFlag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] scFlag, hss, conv, freq, hssB, convB;
    int error_cnt, n_checks;

    // ======================================================
    // Design and checker
    psv_bus_if i_psv_bus_if();
    psv_bus_if i_psv_bus_if_b();
    psv_host #(.QTR_CYC(QTR)) i_psv_host(.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .bus(i_psv_bus_if));
    psv_target i_psv_target(.clk_sys(clk_sys), .rst_n(rst_n), .bus(i_psv_bus_if),
        .uvFlag(uvFlag), .ovFlag(ovFlag), .shortCircuitFlag(scFlag),
        .high_side_switch_enable(hss), .converter_enable(conv), .freqAdjust(freq));
    psv_target i_psv_target_b(.clk_sys(clk_sys), .rst_n(rst_n), .bus(i_psv_bus_if_b),
        .uvFlag(uvFlag), .ovFlag(ovFlag), .shortCircuitFlag(scFlag),
        .high_side_switch_enable(hssB), .converter_enable(convB), .freqAdjust());
    psv_checker #(.QTR_CYC(QTR)) i_psv_checker(.clk_sys(clk_sys), .rst_n(rst_n),
        .hostSclO(i_psv_bus_if.hostSclO), .hostSclOe(i_psv_bus_if.hostSclOe),
        .hostSdaO(i_psv_bus_if.hostSdaO), .hostSdaOe(i_psv_bus_if.hostSdaOe),
        .devSdaO(i_psv_bus_if.devSdaO), .devSdaOe(i_psv_bus_if.devSdaOe),
        .scl(i_psv_bus_if.scl), .sda(i_psv_bus_if.sda));

    // ======================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        chk("apb wait", n, 32'h2);
        @(posedge clk_sys);
    endtask : apb

    task automatic xfer(input logic [7:0] sel, input logic [7:0] dat, input logic rd,
                        output logic [31:0] s);
        logic e;
        int n;
        logic [1:0] acc;
        apb(1'h1, `PSV_REG_SEL, {24'h0, sel}, s, e);
        apb(1'h1, `PSV_REG_WDATA, {24'h0, dat}, s, e);
        apb(1'h1, `PSV_REG_CMD, {30'h0, rd, 1'h1}, s, e);
        n = 0;
        acc = 2'h0;
        do begin
            apb(1'h0, `PSV_REG_STS, 32'h0, s, e);
            acc |= s[1:0];
            n++;
        end while (s[0] !== 1'h1 && n < 2000);
        s[1:0] = acc;
        chk("xfer done", s[0], 1'h1);
        chk("masked irq", {31'h0, irq}, 32'h0);
    endtask : xfer

    task automatic bb_byte(input logic [7:0] b, output logic ack);
        logic [8:0] s;
        s = {b, 1'h1};
        for (int i = 0; i < 9; i++) begin
            i_psv_bus_if_b.hostSdaOe <= ~s[8 - i];
            repeat (QTR) @(posedge clk_sys);
            i_psv_bus_if_b.hostSclOe <= 1'h0;
            repeat (QTR) @(posedge clk_sys);
            ack = i_psv_bus_if_b.sda;
            repeat (QTR) @(posedge clk_sys);
            i_psv_bus_if_b.hostSclOe <= 1'h1;
            repeat (QTR) @(posedge clk_sys);
        end
    endtask : bb_byte

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // ======================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'h0, `PSV_REG_MASK, 32'h0, r, e);
        chk("mask reset", r, {30'h0, `PSV_MASK_RST});
        apb(1'h0, 8'h18, 32'h0, r, e);
        chk("unmapped", {e, r[30:0]}, 32'h8000_0000);
        apb(1'h1, `PSV_REG_SEL, 32'hFFFF_FF5A, r, e);
        apb(1'h0, `PSV_REG_SEL, 32'h0, r, e);
        chk("select back", r, 32'h5A);
        $display("test regs done");
    endtask : t_regs

    task automatic t_write();
        logic [31:0] s;
        xfer(`PSV_SEL_CHAN, 8'h2D, 1'h0, s);
        chk("chan a", {s[2:0], hss, conv}, {3'h1, 3'h6, 3'h3});
        xfer(`PSV_SEL_CHAN, 8'h12, 1'h0, s);
        chk("chan b", {hss, conv}, {3'h1, 3'h4});
        for (int c = 0; c < 6; c++) begin
            xfer(`PSV_SEL_FREQ, 8'(c), 1'h0, s);
            chk("freq", freq, (c == 5) ? 32'h4 : 32'(c));
        end
        xfer(8'h02, 8'h3F, 1'h0, s);
        chk("bad select", {s[1:0], hss, conv}, {2'h3, 3'h1, 3'h4});
        $display("test write done");
    endtask : t_write

    task automatic t_read();
        logic [31:0] r;
        logic e;
        for (int k = 0; k < 2; k++) begin
            {uvFlag, ovFlag, scFlag} <= (k == 0) ? 5'h11 : 5'h0E;
            xfer(8'h00, 8'h00, 1'h1, r);
            apb(1'h0, `PSV_REG_RDATA, 32'h0, r, e);
            chk("status", r, {24'h0, 3'h0, scFlag[0], scFlag[1], scFlag[2], ovFlag, uvFlag});
        end
        $display("test read done");
    endtask : t_read

    task automatic t_irq();
        logic [31:0] r;
        logic e;
        int n;
        apb(1'h1, `PSV_REG_MASK, 32'h1, r, e);
        apb(1'h1, `PSV_REG_CMD, 32'h1, r, e);
        n = 0;
        while (irq !== 1'h1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1'h0, `PSV_REG_STS, 32'h0, r, e);
        chk("irq status", r, 32'h1);
        @(posedge clk_sys);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        chk("zero data", {hss, conv}, 6'h0);
        apb(1'h1, `PSV_REG_MASK, 32'h0, r, e);
        $display("test irq done");
    endtask : t_irq

    task automatic t_far();
        logic a0, a1, a2;
        for (int k = 0; k < 2; k++) begin
            i_psv_bus_if_b.hostSdaOe <= 1'h1;
            repeat (3 * QTR) @(posedge clk_sys);
            i_psv_bus_if_b.hostSclOe <= 1'h1;
            repeat (QTR) @(posedge clk_sys);
            bb_byte((k == 0) ? 8'h82 : {`PSV_TGT_ADDR, 1'h0}, a0);
            bb_byte(`PSV_SEL_CHAN, a1);
            bb_byte(8'h03, a2);
            i_psv_bus_if_b.hostSdaOe <= 1'h1;
            repeat (QTR) @(posedge clk_sys);
            i_psv_bus_if_b.hostSclOe <= 1'h0;
            repeat (2 * QTR) @(posedge clk_sys);
            i_psv_bus_if_b.hostSdaOe <= 1'h0;
            repeat (4 * QTR) @(posedge clk_sys);
            chk("far acks", {a0, a1, a2}, (k == 0) ? 3'h7 : 3'h0);
            chk("far chan", {hssB, convB}, (k == 0) ? 6'h00 : 6'h09);
        end
        $display("test far done");
    endtask : t_far

    // ======================================================
    // Clock, sequence and watchdog
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        rst_n = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {uvFlag, ovFlag, scFlag} = 5'h0;
        {i_psv_bus_if_b.hostSclO, i_psv_bus_if_b.hostSdaO} = 2'h0;
        {i_psv_bus_if_b.hostSclOe, i_psv_bus_if_b.hostSdaOe} = 2'h0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        t_regs();
        t_write();
        t_read();
        t_irq();
        t_far();
        test_done();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        test_done();
    end
endmodule : power_supervisor_i2c_target_tb
